// [vpa_defines.vh]
// Purpose: Constants for the video picture adjust stage.
// Assumes: 8-bit register offsets, 8-bit 601 pixel codes.
// Notes: Definitions only.
`ifndef VPA_DEFINES_VH
`define VPA_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define VPA_OFS_CTRL_ONE 8'h03
`define VPA_OFS_CTRL_TWO 8'h04
`define VPA_OFS_LUMA_GAIN 8'h06
`define VPA_OFS_LUMA_OFFSET 8'h07
`define VPA_OFS_CHROMA_GAIN 8'h08
`define VPA_OFS_CHROMA_PHASE 8'h09
`define VPA_OFS_STATUS 8'h10

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define VPA_RST_CTRL_ONE 8'h00
`define VPA_RST_CTRL_TWO 8'h00
`define VPA_RST_LUMA_GAIN 8'h80
`define VPA_RST_LUMA_OFFSET 8'h00
`define VPA_RST_CHROMA_GAIN 8'h80
`define VPA_RST_CHROMA_PHASE 8'h00
`define VPA_CTRL_ONE_MASK 8'h7F

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VPA_KSEL_LSB 1
`define VPA_KSEL_MSB 2
`define VPA_KILL_OFF_BIT 2
`define VPA_FRATE_LSB 3
`define VPA_FRATE_MSB 4
`define VPA_PARITY_BIT 5
`define VPA_PIVOT_BIT 7
`define VPA_STAT_KILL_BIT 1

// ----------------------------------------------------------------
// Codes
// ----------------------------------------------------------------
`define VPA_KSEL_EITHER 2'h0
`define VPA_KSEL_PLL 2'h1
`define VPA_KSEL_BURST 2'h2
`define VPA_FRATE_FULL 2'h0
`define VPA_FRATE_HALF 2'h1
`define VPA_FRATE_QUARTER 2'h2

// ----------------------------------------------------------------
// Pixel levels
// ----------------------------------------------------------------
`define VPA_Y_MID 10'h080
`define VPA_PIVOT_HIGH 19'h0007D
`define VPA_PIVOT_LOW 19'h00010
`define VPA_CLIP_LO 8'h01
`define VPA_CLIP_HI 8'hFE
`define VPA_LIM_LO 8'h10
`define VPA_LIM_Y_HI 8'hEB
`define VPA_LIM_C_HI 8'hF0
`define VPA_BLACK_Y 8'h10
`define VPA_NEUTRAL_C 8'h80
`define VPA_OFFSET_MINUS_128 8'h80
`define VPA_OFFSET_MINUS_127 8'h81

// Hue: sine in Q16 is about code * 400 (0.35 degree per code)
`define VPA_HUE_SIN_STEP 18'h00190
`define VPA_ONE_Q16 18'h10000

// ----------------------------------------------------------------
// Active line windows
// ----------------------------------------------------------------
`define VPA_L525_A_FIRST 10'h016
`define VPA_L525_A_LAST 10'h105
`define VPA_L525_B_FIRST 10'h11D
`define VPA_L525_B_LAST 10'h20C
`define VPA_L625_A_FIRST 10'h017
`define VPA_L625_A_LAST 10'h136
`define VPA_L625_B_FIRST 10'h150
`define VPA_L625_B_LAST 10'h26F

`endif

// [vpa_host_model.sv]
// Purpose: Host model driving the byte-wide register port.
// Assumes: One access per call, launched just after a clock edge.
// Notes: Reserved field codes are never sent to the device.
`timescale 1ns/100ps
`default_nettype none
module vpa_host_model (
  input wire logic clk,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  input wire logic [7:0] reg_rdata
);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    // Undefined behaviour behind these codes, so fall back to the default
    if (a == 8'h03 && v[2:1] == 2'h3) v[2:1] = 2'h0;
    if (a == 8'h04 && v[4:3] == 2'h3) v[4:3] = 2'h0;
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule // vpa_host_model
`default_nettype wire

// [vpa_picture_adjust.v]
// Purpose: Picture adjust stage: chroma killer, frame decimation,
//   field select, contrast, brightness, saturation, hue, blanking.
// Assumes: Pixels arrive synchronous to clk with line number and
//   field flags from the sync stage; registers written by the
//   serial-bus slave through a simple byte port.
// Notes: One register stage from pixel in to pixel out.
`timescale 1ns/100ps
`default_nettype none
`include "vpa_defines.vh"

module vpa_picture_adjust (
  input wire clk,
  input wire srst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire pix_valid,
  input wire [7:0] y_in,
  input wire [7:0] cb_in,
  input wire [7:0] cr_in,
  input wire [9:0] line_num,
  input wire sys_625,
  input wire field_even,
  input wire frame_start,
  input wire single_field,
  input wire limit_601,
  input wire burst_weak,
  input wire pll_unlock,
  output reg [7:0] y_out,
  output reg [7:0] cb_out,
  output reg [7:0] cr_out,
  output reg pix_out_valid,
  output reg kill_active
);

  // --------------------------------------------------------------
  // Clip helpers
  // --------------------------------------------------------------
  function [7:0] vpa_clip;
    input signed [18:0] v;
    input lim;
    input [7:0] lim_hi;
    reg [7:0] lo;
    reg [7:0] hi;
    begin
      lo = lim ? `VPA_LIM_LO : `VPA_CLIP_LO;
      hi = lim ? lim_hi : `VPA_CLIP_HI;
      if (v < $signed({11'h000, lo})) begin
        vpa_clip = lo;
      end else if (v > $signed({11'h000, hi})) begin
        vpa_clip = hi;
      end else begin
        vpa_clip = v[7:0];
      end
    end
  endfunction

  // --------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------
  reg [7:0] ctrl_one_r;
  reg [7:0] ctrl_two_r;
  reg [7:0] luma_gain_r;
  reg [7:0] luma_offset_r;
  reg [7:0] chroma_gain_r;
  reg [7:0] chroma_phase_r;
  reg [7:0] rdata_nxt;

  always @(posedge clk) begin
    if (srst) begin
      ctrl_one_r <= `VPA_RST_CTRL_ONE;
      ctrl_two_r <= `VPA_RST_CTRL_TWO;
      luma_gain_r <= `VPA_RST_LUMA_GAIN;
      luma_offset_r <= `VPA_RST_LUMA_OFFSET;
      chroma_gain_r <= `VPA_RST_CHROMA_GAIN;
      chroma_phase_r <= `VPA_RST_CHROMA_PHASE;
    end else if (reg_wr) begin
      case (reg_addr)
        `VPA_OFS_CTRL_ONE: begin
          // Reserved top bit is not stored and reads as zero
          ctrl_one_r <= reg_wdata & `VPA_CTRL_ONE_MASK;
        end
        `VPA_OFS_CTRL_TWO: begin
          ctrl_two_r <= reg_wdata;
        end
        `VPA_OFS_LUMA_GAIN: begin
          luma_gain_r <= reg_wdata;
        end
        `VPA_OFS_LUMA_OFFSET: begin
          luma_offset_r <= reg_wdata;
        end
        `VPA_OFS_CHROMA_GAIN: begin
          chroma_gain_r <= reg_wdata;
        end
        `VPA_OFS_CHROMA_PHASE: begin
          chroma_phase_r <= reg_wdata;
        end
        default: begin
          ctrl_one_r <= ctrl_one_r;
        end
      endcase
    end
  end

  always @* begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      `VPA_OFS_CTRL_ONE: rdata_nxt = ctrl_one_r;
      `VPA_OFS_CTRL_TWO: rdata_nxt = ctrl_two_r;
      `VPA_OFS_LUMA_GAIN: rdata_nxt = luma_gain_r;
      `VPA_OFS_LUMA_OFFSET: rdata_nxt = luma_offset_r;
      `VPA_OFS_CHROMA_GAIN: rdata_nxt = chroma_gain_r;
      `VPA_OFS_CHROMA_PHASE: rdata_nxt = chroma_phase_r;
      `VPA_OFS_STATUS: rdata_nxt[`VPA_STAT_KILL_BIT] = kill_active;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end
  end

  // --------------------------------------------------------------
  // Field decode
  // --------------------------------------------------------------
  wire [1:0] kill_sel = ctrl_one_r[`VPA_KSEL_MSB:`VPA_KSEL_LSB];
  wire kill_off = ctrl_two_r[`VPA_KILL_OFF_BIT];
  wire [1:0] frame_rate_select = ctrl_two_r[`VPA_FRATE_MSB:`VPA_FRATE_LSB];
  wire field_parity_select = ctrl_two_r[`VPA_PARITY_BIT];
  wire contrast_pivot_select = ctrl_two_r[`VPA_PIVOT_BIT];

  // --------------------------------------------------------------
  // Chroma killer
  // --------------------------------------------------------------
  reg kill_cond;
  always @* begin
    case (kill_sel)
      `VPA_KSEL_EITHER: kill_cond = burst_weak | pll_unlock;
      `VPA_KSEL_PLL: kill_cond = pll_unlock;
      `VPA_KSEL_BURST: kill_cond = burst_weak;
      // Reserved code: host must not use it, treat as either
      default: kill_cond = burst_weak | pll_unlock;
    endcase
  end
  wire kill_nxt = ~kill_off & kill_cond;

  always @(posedge clk) begin
    if (srst) begin
      kill_active <= 1'b0;
    end else begin
      kill_active <= kill_nxt;
    end
  end

  // --------------------------------------------------------------
  // Frame decimation and field select
  // --------------------------------------------------------------
  reg [1:0] frame_cnt_r;
  reg frame_keep;
  always @(posedge clk) begin
    if (srst) begin
      frame_cnt_r <= 2'h0;
    end else if (frame_start) begin
      frame_cnt_r <= frame_cnt_r + 2'h1;
    end
  end

  always @* begin
    case (frame_rate_select)
      `VPA_FRATE_FULL: frame_keep = 1'b1;
      `VPA_FRATE_HALF: frame_keep = ~frame_cnt_r[0];
      `VPA_FRATE_QUARTER: frame_keep = (frame_cnt_r == 2'h0);
      default: frame_keep = 1'b1;
    endcase
  end

  // Odd field when parity bit is 0, even field when 1
  wire field_ok = ~single_field | (field_even == field_parity_select);

  // --------------------------------------------------------------
  // Active line window
  // --------------------------------------------------------------
  wire act_525 = ((line_num >= `VPA_L525_A_FIRST) &&
                  (line_num <= `VPA_L525_A_LAST)) ||
                 ((line_num >= `VPA_L525_B_FIRST) &&
                  (line_num <= `VPA_L525_B_LAST));
  wire act_625 = ((line_num >= `VPA_L625_A_FIRST) &&
                  (line_num <= `VPA_L625_A_LAST)) ||
                 ((line_num >= `VPA_L625_B_FIRST) &&
                  (line_num <= `VPA_L625_B_LAST));
  wire line_active = sys_625 ? act_625 : act_525;

  // --------------------------------------------------------------
  // Luma: contrast then brightness
  // --------------------------------------------------------------
  wire signed [9:0] y_ctr = $signed({2'h0, y_in}) - $signed(`VPA_Y_MID);
  // Gain is unsigned, so widen with a zero sign bit
  wire signed [18:0] y_mul = y_ctr * $signed({1'b0, luma_gain_r});
  wire signed [18:0] y_scaled = y_mul >>> 7;
  wire signed [18:0] y_pivot = contrast_pivot_select ?
    $signed(`VPA_PIVOT_LOW) : $signed(`VPA_PIVOT_HIGH);
  wire signed [18:0] y_con = y_scaled + y_pivot;
  wire [7:0] y_con_clip = vpa_clip(y_con, limit_601, `VPA_LIM_Y_HI);

  // Code 0x80 would be -128, beyond the offset range
  wire [7:0] offset_eff = (luma_offset_r == `VPA_OFFSET_MINUS_128) ?
    `VPA_OFFSET_MINUS_127 : luma_offset_r;
  wire signed [18:0] y_bri = $signed({11'h000, y_con_clip}) +
    $signed({{11{offset_eff[7]}}, offset_eff});
  wire [7:0] y_adj = vpa_clip(y_bri, limit_601, `VPA_LIM_Y_HI);

  // --------------------------------------------------------------
  // Chroma: saturation then hue rotation
  // --------------------------------------------------------------
  // Incoming chroma is already levelled by the colour control
  wire signed [8:0] u_ctr = $signed({1'b0, cb_in}) - $signed(9'h080);
  wire signed [8:0] v_ctr = $signed({1'b0, cr_in}) - $signed(9'h080);
  wire signed [17:0] u_mul =
    u_ctr * $signed({1'b0, chroma_gain_r});
  wire signed [17:0] v_mul =
    v_ctr * $signed({1'b0, chroma_gain_r});
  wire signed [17:0] u_sat = u_mul >>> 7;
  wire signed [17:0] v_sat = v_mul >>> 7;

  // Small-angle sine and cosine; error reaches about ten codes near 45 deg for full-scale chroma at unity gain
  wire signed [17:0] hue_sin = $signed(chroma_phase_r) *
    $signed(`VPA_HUE_SIN_STEP);
  wire signed [35:0] hue_sq = hue_sin * hue_sin;
  wire signed [35:0] hue_sq_half = hue_sq >>> 17;
  wire signed [17:0] hue_cos = $signed(`VPA_ONE_Q16) -
    hue_sq_half[17:0];
  wire signed [35:0] u_rot = u_sat * hue_cos - v_sat * hue_sin;
  wire signed [35:0] v_rot = v_sat * hue_cos + u_sat * hue_sin;
  wire signed [35:0] u_rsh = u_rot >>> 16;
  wire signed [35:0] v_rsh = v_rot >>> 16;
  wire signed [18:0] u_fin = u_rsh[18:0] + $signed(19'h00080);
  wire signed [18:0] v_fin = v_rsh[18:0] + $signed(19'h00080);
  wire [7:0] cb_adj = vpa_clip(u_fin, limit_601, `VPA_LIM_C_HI);
  wire [7:0] cr_adj = vpa_clip(v_fin, limit_601, `VPA_LIM_C_HI);

  // --------------------------------------------------------------
  // Output stage
  // --------------------------------------------------------------
  reg [7:0] y_nxt;
  reg [7:0] cb_nxt;
  reg [7:0] cr_nxt;
  always @* begin
    y_nxt = y_adj;
    cb_nxt = cb_adj;
    cr_nxt = cr_adj;
    if (!line_active) begin
      y_nxt = `VPA_BLACK_Y;
      cb_nxt = `VPA_NEUTRAL_C;
      cr_nxt = `VPA_NEUTRAL_C;
    end else if (kill_nxt) begin
      cb_nxt = `VPA_NEUTRAL_C;
      cr_nxt = `VPA_NEUTRAL_C;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      y_out <= `VPA_BLACK_Y;
      cb_out <= `VPA_NEUTRAL_C;
      cr_out <= `VPA_NEUTRAL_C;
      pix_out_valid <= 1'b0;
    end else begin
      pix_out_valid <= pix_valid & frame_keep & field_ok;
      if (pix_valid) begin
        y_out <= y_nxt;
        cb_out <= cb_nxt;
        cr_out <= cr_nxt;
      end
    end
  end

endmodule // vpa_picture_adjust
`default_nettype wire

// [vpa_picture_adjust_chk.sv]
// Purpose: Port-level assertions for the picture adjust stage.
// Assumes: Single clock domain, synchronous active-high reset.
// Notes: Register contents are not shadowed here; the bench does that.
`timescale 1ns/100ps
`default_nettype none
module vpa_picture_adjust_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic pix_valid,
  input wire logic [9:0] line_num,
  input wire logic sys_625,
  input wire logic limit_601,
  input wire logic burst_weak,
  input wire logic pll_unlock,
  input wire logic [7:0] y_out,
  input wire logic [7:0] cb_out,
  input wire logic [7:0] cr_out,
  input wire logic pix_out_valid,
  input wire logic kill_active
);
  default clocking dclk @(posedge clk);
  endclocking
  default disable iff (srst);
  logic bl_a;
  logic bl_b;
  assign bl_a = !sys_625 && (line_num < 10'h016 || line_num > 10'h20C ||
    (line_num > 10'h105 && line_num < 10'h11D));
  assign bl_b = sys_625 && (line_num < 10'h017 || line_num > 10'h26F ||
    (line_num > 10'h136 && line_num < 10'h150));
  blank_ntsc_a: assert property (
    pix_valid && bl_a |=> y_out == 8'h10 && {cb_out, cr_out} == 16'h8080)
    else $error("525 blank line not black");
  blank_pal_a: assert property (
    pix_valid && bl_b |=> y_out == 8'h10 && {cb_out, cr_out} == 16'h8080)
    else $error("625 blank line not black");
  kill_neutral_a: assert property (
    pix_valid ##1 kill_active |-> {cb_out, cr_out} == 16'h8080)
    else $error("killed chroma not neutral");
  kill_cause_a: assert property (
    !burst_weak && !pll_unlock |=> !kill_active)
    else $error("killer active without cause");
  valid_cause_a: assert property (pix_out_valid |-> $past(pix_valid))
    else $error("output valid without input pixel");
  luma_clip_a: assert property (
    pix_valid |=> y_out != 8'h00 && y_out != 8'hFF)
    else $error("luma outside 1..254");
  luma_limit_a: assert property (
    pix_valid && limit_601 |=> y_out >= 8'h10 && y_out <= 8'hEB)
    else $error("luma outside 16..235");
  kill_status_a: assert property (
    reg_rd && reg_addr == 8'h10 |=>
      reg_rdata == {6'h00, $past(kill_active), 1'b0})
    else $error("status read mismatch");
endmodule // vpa_picture_adjust_chk
bind vpa_picture_adjust vpa_picture_adjust_chk chk (.clk, .srst, .reg_addr,
  .reg_rd, .reg_rdata, .pix_valid, .line_num, .sys_625, .limit_601,
  .burst_weak, .pll_unlock, .y_out, .cb_out, .cr_out, .pix_out_valid,
  .kill_active);
`default_nettype wire

// [vpa_picture_adjust_test.sv]
// Purpose: Self-checking bench for the picture adjust stage.
// Assumes: Host model owns the register port; bench drives pixels.
// Notes: Expected pixels come from an integer model held here.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) \
  compares++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("Error at %0t got %h exp %h", $time, (g), (e)); \
  end
module vpa_picture_adjust_test;
  logic clk = 1'b0, srst = 1'b1, pix_valid = 1'b0, frame_start = 1'b0;
  logic sys_625 = 1'b0, field_even = 1'b0, single_field = 1'b0;
  logic limit_601 = 1'b0, burst_weak = 1'b0, pll_unlock = 1'b0;
  logic [7:0] y_in = 8'h10, cb_in = 8'h80, cr_in = 8'h80, d;
  logic [9:0] line_num = 10'h064;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, y_out, cb_out, cr_out;
  logic reg_wr, reg_rd, pix_out_valid, kill_active;
  logic [3:0] kept;
  int bad_count = 0, compares = 0, c1 = 0, c2 = 0;
  int g = 128, o = 0, s = 128, h = 0;
  int ofs[6] = '{8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09};
  int rv[6] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00};
  int bl[16] = '{21, 22, 261, 262, 284, 285, 524, 525,
    22, 23, 310, 311, 335, 336, 623, 624};
  vpa_picture_adjust uut (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .pix_valid, .y_in, .cb_in, .cr_in, .line_num,
    .sys_625, .field_even, .frame_start, .single_field, .limit_601,
    .burst_weak, .pll_unlock, .y_out, .cb_out, .cr_out, .pix_out_valid,
    .kill_active);
  vpa_host_model host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata);
  initial forever #2.5 clk = ~clk;
  function automatic int clip(int v, int lo, int hi);
    return v < lo ? lo : (v > hi ? hi : v);
  endfunction
  task automatic results;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic setr(input int a, input int v);
    host.wr(8'(a), 8'(v));
    case (a)
      3: c1 = v & 8'h7F;
      4: c2 = v;
      6: g = v;
      7: o = v;
      8: s = v;
      9: h = v;
    endcase
  endtask
  task automatic px(input int y, input int cb, input int cr, input int ln);
    longint u, v, sn, cs;
    int lo, off, ey, eu, ev;
    bit act, kill, keep;
    // Inputs set by NBA at the last edge are only settled after this one
    @(posedge clk);
    act = sys_625 ? (ln >= 23 && ln <= 310) || (ln >= 336 && ln <= 623)
      : (ln >= 22 && ln <= 261) || (ln >= 285 && ln <= 524);
    lo = limit_601 ? 16 : 1;
    off = o > 127 ? o - 256 : o;
    if (off == -128) off = -127;
    ey = clip((((y - 128) * g) >>> 7) + (c2[7] ? 16 : 125), lo,
      limit_601 ? 235 : 254);
    ey = clip(ey + off, lo, limit_601 ? 235 : 254);
    u = ((cb - 128) * s) >>> 7;
    v = ((cr - 128) * s) >>> 7;
    sn = (h > 127 ? h - 256 : h) * 400;
    cs = 65536 - ((sn * sn) >>> 17);
    eu = clip(int'(((u * cs - v * sn) >>> 16) + 128), lo,
      limit_601 ? 240 : 254);
    ev = clip(int'(((v * cs + u * sn) >>> 16) + 128), lo,
      limit_601 ? 240 : 254);
    kill = !c2[2] && (c1[2:1] == 1 ? pll_unlock :
      (c1[2:1] == 2 ? burst_weak : burst_weak | pll_unlock));
    if (kill || !act) {eu, ev} = {128, 128};
    if (!act) ey = 16;
    keep = !single_field || field_even == c2[5];
    pix_valid <= 1'b1;
    {y_in, cb_in, cr_in, line_num} <= {8'(y), 8'(cb), 8'(cr), 10'(ln)};
    @(posedge clk);
    pix_valid <= 1'b0;
    #1;
    `CHK(y_out, 8'(ey))
    `CHK({cb_out, cr_out}, {8'(eu), 8'(ev)})
    `CHK(pix_out_valid, keep)
    `CHK(kill_active, kill)
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    results();
  end
  initial begin
    void'($urandom(32'hB0B182D9));
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    #1;
    `CHK({y_out, cb_out, cr_out}, 24'h108080)
    `CHK({pix_out_valid, kill_active, reg_rdata}, 10'h000)
    for (int k = 0; k < 6; k++) begin
      host.rd(8'(ofs[k]), d);
      `CHK(d, 8'(rv[k]))
      setr(ofs[k], k == 1 ? 8'hE7 : 8'hF9);
      host.rd(8'(ofs[k]), d);
      `CHK(d, k == 0 ? 8'h79 : (k == 1 ? 8'hE7 : 8'hF9))
      setr(ofs[k], rv[k]);
    end
    host.wr(8'h05, 8'hFF);
    host.rd(8'h05, d);
    `CHK(d, 8'h00)
    host.wr(8'h10, 8'hFF);
    host.rd(8'h10, d);
    `CHK(d, 8'h00)
    px(8'h80, 8'h80, 8'h80, 100);
    for (int k = 0; k < 16; k++) begin
      @(posedge clk);
      sys_625 <= k > 7;
      px(8'hC0, 8'h20, 8'hE0, bl[k]);
    end
    for (int i = 0; i < 300; i++) begin
      if (i % 20 == 0) begin
        setr(3, ((i / 20) % 3) << 1);
        setr(4, $urandom & 8'hA4);
        setr(6, $urandom % 256);
        setr(7, $urandom % 256);
        setr(8, $urandom % 256);
        setr(9, ($urandom % 255 + 129) % 256);
      end
      @(posedge clk);
      {sys_625, limit_601, burst_weak, pll_unlock, field_even,
        single_field} <= 6'($urandom);
      px($urandom % 256, $urandom % 256, $urandom % 256, 1 + $urandom % 625);
    end
    single_field <= 1'b0;
    for (int r = 0; r < 3; r++) begin
      setr(4, r << 3);
      kept = 4'h0;
      // Eight frames make the count independent of the counter phase
      repeat (8) begin
        @(posedge clk);
        frame_start <= 1'b1;
        @(posedge clk);
        frame_start <= 1'b0;
        pix_valid <= 1'b1;
        @(posedge clk);
        pix_valid <= 1'b0;
        #1;
        kept = kept + 4'(pix_out_valid);
      end
      `CHK(kept, 4'(8 >> r))
    end
    // Reset again mid-run: outputs and registers return to defaults
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1;
    `CHK({y_out, cb_out, cr_out}, 24'h108080)
    `CHK({pix_out_valid, kill_active, reg_rdata}, 10'h000)
    c1 = 0;
    c2 = 0;
    g = 128;
    o = 0;
    s = 128;
    h = 0;
    for (int k = 0; k < 6; k++) begin
      host.rd(8'(ofs[k]), d);
      `CHK(d, 8'(rv[k]))
    end
    px(8'h80, 8'h80, 8'h80, 100);
    results();
  end
endmodule // vpa_picture_adjust_test
`default_nettype wire
